/* File: design/flash_program_erase_ctrl.sv */
// program/erase sequencer with array model and protection
//
// Function
// - high voltage may set only with a select bit and correct step order
// - high voltage bit drives pump and array high voltage
// - row-write and block-clear selects never both one
// - mass select with block-clear erases whole memory
// - page erase clears aligned 64 bytes; vector area is one page
// - erased cells read one, programmed cells read zero
// - read access returns after recovery delay once high voltage clears
// - mass erase refused while any block protected; code only checks a mass bit set before high voltage, not with or after it
// - mass or vector-page erase also clears trim byte
// - programming works on aligned 32-byte rows
// - either select latches address of first array write after protect read; data is not latched
// - protected range runs from start address to top
// - zero protects all, all ones protects none
// - protect register locked while any block protected, unless test high voltage present
// - protect bits are start address bits 13 to 6
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module flash_program_erase_ctrl #(
    parameter int MEM_BYTES = 8192
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire nvm_ctrl_pkg::bus_req_t req_i,
    input wire logic test_high_voltage_i,
    output logic [7:0] rdata_o,
    output logic pump_on_o,
    output logic array_hv_o,
    output logic read_ready_o
);
    import nvm_ctrl_pkg::*;

    typedef enum {ST_IDLE, ST_SEL, ST_PROT, ST_LATCH, ST_ARMED, ST_HV} seq_t;

    localparam logic [15:0] BASE = 16'(17'h10000 - 17'(MEM_BYTES));

    ctrl_t ctrl;
    seq_t seq;
    logic [7:0] mem [0:MEM_BYTES-1];
    logic [15:0] latch_addr;
    logic [15:0] setup_cnt;
    logic [15:0] rcv_cnt;
    logic hv_allowed;
    logic [15:0] prot_start;
    logic prot_hit;
    logic prot_any;
    logic erase_go;
    logic ctrl_wr;
    logic arr_wr;
    logic [7:0] next_ctrl_byte;
    logic [7:0] wb;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= BASE);
    endfunction : in_array

    function automatic logic [12:0] idx(input logic [15:0] a);
        idx = 13'(a - BASE);
    endfunction : idx

    assign ctrl_wr = req_i.wr && (req_i.addr == CTRL_ADDR);
    assign arr_wr = req_i.wr && in_array(req_i.addr);
    assign wb = req_i.wdata;

    nvm_prot_decode u_prot (
        .prot_i(mem[idx(PROT_ADDR)]),
        .addr_i(latch_addr),
        .start_o(prot_start),
        .hit_o(prot_hit),
        .any_o(prot_any)
    );

    // protection, mass lock and step order gate high voltage
    always_comb begin
        hv_allowed = (seq == ST_ARMED) && (ctrl.row_sel ^ ctrl.clr_sel);
        if (prot_hit && !test_high_voltage_i) begin
            hv_allowed = 1'b0;
        end
        if (ctrl.clr_sel && ctrl.mass_sel && prot_any) begin
            hv_allowed = 1'b0;
        end
    end

    // control byte update
    always_comb begin
        next_ctrl_byte = {4'h0, ctrl.hv_on, ctrl.mass_sel, ctrl.clr_sel, ctrl.row_sel};
        if (ctrl_wr) begin
            next_ctrl_byte[BIT_MASS] = wb[BIT_MASS];
            if (wb[BIT_ROW] && wb[BIT_CLR]) begin
                next_ctrl_byte[BIT_ROW] = ctrl.row_sel;
                next_ctrl_byte[BIT_CLR] = ctrl.clr_sel;
            end else begin
                next_ctrl_byte[BIT_ROW] = wb[BIT_ROW] && !ctrl.clr_sel;
                next_ctrl_byte[BIT_CLR] = wb[BIT_CLR] && !ctrl.row_sel;
            end
            if (!wb[BIT_HV]) begin
                next_ctrl_byte[BIT_HV] = 1'b0;
            end else if (!ctrl.hv_on) begin
                next_ctrl_byte[BIT_HV] = hv_allowed;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl <= '0;
        end else begin
            ctrl.row_sel <= next_ctrl_byte[BIT_ROW];
            ctrl.clr_sel <= next_ctrl_byte[BIT_CLR];
            ctrl.mass_sel <= next_ctrl_byte[BIT_MASS];
            ctrl.hv_on <= next_ctrl_byte[BIT_HV];
        end
    end

    // step order tracker
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            seq <= ST_IDLE;
            latch_addr <= 16'h0000;
            setup_cnt <= 16'h0000;
        end else begin
            case (seq)
                ST_IDLE: begin
                    if (ctrl.row_sel || ctrl.clr_sel) begin
                        if (req_i.rd && req_i.addr == PROT_ADDR) begin
                            seq <= ST_LATCH;
                        end else begin
                            seq <= ST_PROT;
                        end
                    end
                end
                ST_PROT: begin
                    if (req_i.rd && req_i.addr == PROT_ADDR) begin
                        seq <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    if (arr_wr) begin
                        latch_addr <= req_i.addr;
                        setup_cnt <= 16'h0000;
                        seq <= ST_SEL;
                    end
                end
                ST_SEL: begin
                    if (setup_cnt >= 16'(SETUP_CYCLES - 1)) begin
                        seq <= ST_ARMED;
                    end else begin
                        setup_cnt <= setup_cnt + 16'h0001;
                    end
                end
                ST_ARMED: begin
                    if (ctrl.hv_on) begin
                        seq <= ST_HV;
                    end
                end
                ST_HV: begin
                    if (!ctrl.hv_on) begin
                        seq <= ST_IDLE;
                    end
                end
                default: seq <= ST_IDLE;
            endcase
            if (!ctrl.row_sel && !ctrl.clr_sel && !ctrl.hv_on) begin
                seq <= ST_IDLE;
            end
        end
    end

    // erase fires when select clears with high voltage on
    assign erase_go = ctrl.clr_sel && ctrl.hv_on && ctrl_wr && !wb[BIT_CLR];

    // array contents
    always_ff @(posedge ref_clk_i) begin
        if (erase_go) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                logic [15:0] a;
                a = BASE + 16'(i);
                if (ctrl.mass_sel) begin
                    mem[i] <= ERASED_BYTE;
                end else if (latch_addr >= VEC_PAGE_LO) begin
                    if (a >= VEC_PAGE_LO) begin
                        mem[i] <= ERASED_BYTE;
                    end
                end else if (a[15:6] == latch_addr[15:6]) begin
                    mem[i] <= ERASED_BYTE;
                end
            end
        end else if (arr_wr && ctrl.row_sel && ctrl.hv_on && seq == ST_HV) begin
            if (req_i.addr[15:5] == latch_addr[15:5]) begin
                mem[idx(req_i.addr)] <= mem[idx(req_i.addr)] & wb;
            end
        end
        // other array writes leave contents as is
    end

    // recovery counter after high voltage drops
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rcv_cnt <= 16'h0000;
            read_ready_o <= 1'b1;
        end else if (ctrl.hv_on) begin
            rcv_cnt <= 16'(RECOVERY_CYCLES);
            read_ready_o <= 1'b0;
        end else if (rcv_cnt != 16'h0000) begin
            rcv_cnt <= rcv_cnt - 16'h0001;
            read_ready_o <= (rcv_cnt == 16'h0001);
        end else begin
            read_ready_o <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pump_on_o <= 1'b0;
            array_hv_o <= 1'b0;
        end else begin
            pump_on_o <= next_ctrl_byte[BIT_HV];
            array_hv_o <= next_ctrl_byte[BIT_HV];
        end
    end

    // read port, one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            if (req_i.addr == CTRL_ADDR) begin
                rdata_o <= {4'h0, ctrl.hv_on, ctrl.mass_sel, ctrl.clr_sel, ctrl.row_sel};
            end else if (in_array(req_i.addr)) begin
                rdata_o <= mem[idx(req_i.addr)];
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end

    property p_interlock;
        @(posedge ref_clk_i) disable iff (srst_i) !(ctrl.row_sel && ctrl.clr_sel);
    endproperty
    a_interlock: assert property (p_interlock) else $error("both selects set");
    property p_hv_needs_sel;
        @(posedge ref_clk_i) disable iff (srst_i) $rose(ctrl.hv_on) |-> $past(seq) == ST_ARMED;
    endproperty
    a_hv_needs_sel: assert property (p_hv_needs_sel) else $error("hv without order");
    property p_pump;
        @(posedge ref_clk_i) disable iff (srst_i) pump_on_o == ctrl.hv_on;
    endproperty
    a_pump: assert property (p_pump) else $error("pump mismatch");
    property p_mass_lock;
        @(posedge ref_clk_i) disable iff (srst_i)
            (ctrl.clr_sel && ctrl.mass_sel && prot_any && !ctrl.hv_on) |=> !ctrl.hv_on;
    endproperty
    a_mass_lock: assert property (p_mass_lock) else $error("mass erase not refused");
    property p_prot;
        @(posedge ref_clk_i) disable iff (srst_i)
            (prot_hit && !test_high_voltage_i && !ctrl.hv_on) |=> !ctrl.hv_on;
    endproperty
    a_prot: assert property (p_prot) else $error("protected block armed");
    property p_rcv;
        @(posedge ref_clk_i) disable iff (srst_i) $fell(ctrl.hv_on) |-> !read_ready_o;
    endproperty
    a_rcv: assert property (p_rcv) else $error("recovery skipped");
    property p_setup;
        @(posedge ref_clk_i) disable iff (srst_i)
            $rose(seq == ST_ARMED) |-> setup_cnt == 16'(SETUP_CYCLES - 1);
    endproperty
    a_setup: assert property (p_setup) else $error("setup wait wrong");
    property p_start;
        @(posedge ref_clk_i) disable iff (srst_i) prot_start[15:14] == PROT_TOP;
    endproperty
    a_start: assert property (p_start) else $error("start address top bits");
    c_hv: cover property (@(posedge ref_clk_i) $rose(ctrl.hv_on));
    c_erase: cover property (@(posedge ref_clk_i) erase_go);
    c_mass: cover property (@(posedge ref_clk_i) erase_go && ctrl.mass_sel);
endmodule : flash_program_erase_ctrl

/* File: design/nvm_ctrl_pkg.sv */
// package for the program/erase control block
package nvm_ctrl_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] CTRL_ADDR = 16'hFE08;
    localparam logic [15:0] PROT_ADDR = 16'hFFBE;
    localparam logic [15:0] TRIM_ADDR = 16'hFFC0;
    localparam logic [15:0] LIVE_ADDR = 16'hFFFF;
    localparam logic [15:0] MEM_LO = 16'hEE00;
    localparam logic [15:0] USER_HI = 16'hFDFF;
    localparam logic [15:0] VEC_LO = 16'hFFD0;
    localparam logic [15:0] VEC_PAGE_LO = 16'hFFC0;
    localparam int BIT_ROW = 0;
    localparam int BIT_CLR = 1;
    localparam int BIT_MASS = 2;
    localparam int BIT_HV = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] PROT_OPEN = 8'hFF;
    localparam logic [1:0] PROT_TOP = 2'h3;
    localparam logic [5:0] PROT_LOW = 6'h00;
    localparam int PAGE_BYTES = 64;
    localparam int ROW_BYTES = 32;
    localparam int CLK_HZ = 10_000_000;
    localparam int SETUP_DELAY_US = 10;
    localparam int RECOVERY_DELAY_US = 1;
    localparam int SETUP_CYCLES = (SETUP_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int RECOVERY_CYCLES = (RECOVERY_DELAY_US * CLK_HZ) / 1_000_000;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef struct packed {
        logic hv_on;
        logic row_sel;
        logic clr_sel;
        logic mass_sel;
    } ctrl_t;
endpackage : nvm_ctrl_pkg

/* File: design/nvm_prot_decode.sv */
// protection start decode and range check
`timescale 1ns/1ps
module nvm_prot_decode (
    input wire logic [7:0] prot_i,
    input wire logic [15:0] addr_i,
    output logic [15:0] start_o,
    output logic hit_o,
    output logic any_o
);
    import nvm_ctrl_pkg::*;
    always_comb begin
        start_o = {PROT_TOP, prot_i, PROT_LOW};
        any_o = (prot_i != PROT_OPEN);
        hit_o = any_o && (addr_i >= start_o);
    end
endmodule : nvm_prot_decode

/* File: verification/tb_top.sv */
// self-checking bench for the program/erase control block
`timescale 1ns/1ps
module tb_top;
    import nvm_ctrl_pkg::*;
    logic ref_clk_i;
    logic srst_i;
    bus_req_t req;
    logic tv;
    logic [7:0] rdata;
    logic pump_on;
    logic array_hv;
    logic read_ready;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic rd_d = 1'b0;
    logic [7:0] row_data[32];
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 86;

    flash_program_erase_ctrl #(.MEM_BYTES(8192)) flash_program_erase_ctrl_inst (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .req_i(req),
        .test_high_voltage_i(tv),
        .rdata_o(rdata),
        .pump_on_o(pump_on),
        .array_hv_o(array_hv),
        .read_ready_o(read_ready)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] x, input string msg);
        n_checks++;
        if (got !== x) begin
            fails++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, x);
        end
    endtask : chk

    // read data watcher, one cycle after each read strobe
    always @(posedge ref_clk_i) begin
        cycles++;
        rd_d <= req.rd;
        if (rd_d) begin
            e = exp_q.pop_front();
            if (!e[8]) chk(rdata, e[7:0], "read data");
        end
        if (cycles > 20000) begin
            fails++;
            $display("FAIL %0t timeout", $time);
            finish_test();
        end
    end

    task automatic op(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge ref_clk_i);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : op

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        op(a, d, 1'b1, 1'b0);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [8:0] x);
        exp_q.push_back(x);
        op(a, 8'h00, 1'b0, 1'b1);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) op(16'h0000, 8'h00, 1'b0, 1'b0);
    endtask : idle

    // select, protect read, dummy write, setup wait, high voltage, read back
    task automatic arm(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] x);
        wr(CTRL_ADDR, sel);
        rd(PROT_ADDR, 9'h100);
        wr(a, 8'($random(seed)));
        idle(SETUP_CYCLES + 2);
        wr(CTRL_ADDR, sel | 8'h08);
        rd(CTRL_ADDR, {1'b0, x});
    endtask : arm

    task automatic done();
        wr(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
        idle(14);
    endtask : done

    initial begin
        srst_i = 1'b1;
        req = '0;
        tv = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1;
        chk({7'h00, pump_on}, 8'h00, "pump at reset");
        chk({7'h00, read_ready}, 8'h01, "ready at reset");
        rd(CTRL_ADDR, 9'h000);
        $display("test reset done");
        // interlock and refused high voltage
        wr(CTRL_ADDR, 8'h03);
        rd(CTRL_ADDR, 9'h000);
        wr(CTRL_ADDR, 8'h01);
        wr(CTRL_ADDR, 8'h03);
        rd(CTRL_ADDR, 9'h001);
        wr(CTRL_ADDR, 8'h09);
        rd(CTRL_ADDR, 9'h001);
        wr(CTRL_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h08);
        rd(CTRL_ADDR, 9'h000);
        wr(CTRL_ADDR, 8'h00);
        $display("test interlock done");
        // unlock protect page with test voltage
        tv <= 1'b1;
        arm(8'h02, 16'hFF80, 8'h0A);
        idle(2);
        #1;
        chk({7'h00, pump_on}, 8'h01, "pump on");
        chk({7'h00, array_hv}, 8'h01, "array hv on");
        wr(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
        idle(3);
        #1;
        chk({7'h00, array_hv}, 8'h00, "array hv off");
        chk({7'h00, read_ready}, 8'h00, "ready low");
        idle(12);
        #1;
        chk({7'h00, read_ready}, 8'h01, "ready back");
        tv <= 1'b0;
        rd(PROT_ADDR, 9'h0FF);
        rd(16'hFF80, 9'h0FF);
        arm(8'h02, 16'hFFE0, 8'h0A);
        done();
        rd(TRIM_ADDR, 9'h0FF);
        rd(16'hFFE0, 9'h0FF);
        $display("test page erase done");
        // mass erase with nothing protected
        arm(8'h06, 16'hE000, 8'h0E);
        done();
        for (int i = 0; i < 6; i++) rd({4'hE, 12'($random(seed))}, 9'h0FF);
        rd(TRIM_ADDR, 9'h0FF);
        $display("test mass erase done");
        // writes without select, then row program
        wr(16'hE060, 8'h00);
        rd(16'hE060, 9'h0FF);
        arm(8'h01, 16'hE020, 8'h09);
        idle(60);
        for (int i = 0; i < 32; i++) begin
            row_data[i] = 8'($random(seed));
            wr(16'hE020 + 16'(i), row_data[i]);
        end
        wr(16'hE040, 8'h00);
        done();
        for (int i = 0; i < 32; i++) rd(16'hE020 + 16'(i), {1'b0, row_data[i]});
        rd(16'hE040, 9'h0FF);
        $display("test program done");
        // protection from EE40 upward
        arm(8'h01, 16'hFFA0, 8'h09);
        wr(PROT_ADDR, 8'hB9);
        done();
        rd(PROT_ADDR, 9'h0B9);
        arm(8'h02, 16'hEE40, 8'h02);
        done();
        arm(8'h02, 16'hEE00, 8'h0A);
        done();
        arm(8'h06, 16'hE000, 8'h06);
        done();
        arm(8'h01, 16'hFFA0, 8'h01);
        done();
        tv <= 1'b1;
        arm(8'h01, 16'hFFA0, 8'h09);
        wr(PROT_ADDR, 8'h00);
        done();
        tv <= 1'b0;
        rd(PROT_ADDR, 9'h000);
        arm(8'h02, 16'hE000, 8'h02);
        done();
        $display("test protection done");
        idle(3);
        finish_test();
    end
endmodule : tb_top
